// >>> etc_pkg.sv
// constants, field layouts and states of the event transfer controller
// assumes a 32-bit descriptor bus and an AXI4-Lite register port
package etc_pkg;
    localparam int ETC_NSRC = 8;
    localparam int ETC_SIW = 3;
    localparam int ETC_AW = 8;
    // register byte offsets
    localparam logic [7:0] ETC_REG_BASE = 8'h00;
    localparam logic [7:0] ETC_REG_EN = 8'h04;
    localparam logic [7:0] ETC_REG_SWC = 8'h08;
    localparam logic [7:0] ETC_REG_STAT = 8'h0C;
    localparam int ETC_SWC_FLAG = 8;
    localparam int ETC_STAT_SRC = 8;
    localparam int ETC_STAT_HW = 12;
    localparam logic [1:0] ETC_RESP_OK = 2'h0;
    localparam logic [1:0] ETC_RESP_ERR = 2'h2;
    // vector table
    localparam logic [31:0] ETC_SW_VEC_BASE = 32'h0000_0400;
    localparam logic [31:0] ETC_HW_VEC_BASE = 32'h0000_0402;
    localparam logic [31:0] ETC_DESC_STRIDE = 32'h0000_0010;
    // transfer_mode_word fields
    localparam int ETC_MW_SM = 14;
    localparam int ETC_MW_DM = 12;
    localparam int ETC_MW_MD = 10;
    localparam int ETC_MW_SIDE = 9;
    localparam int ETC_MW_SZ = 4;
    localparam int ETC_MW_CHAIN = 3;
    localparam int ETC_MW_ISEL = 2;
    localparam logic [1:0] ETC_MD_NORMAL = 2'h0;
    localparam logic [1:0] ETC_MD_REPEAT = 2'h1;
    localparam logic [1:0] ETC_MD_BLOCK = 2'h2;
    localparam logic [1:0] ETC_AM_INC = 2'h2;
    localparam logic [1:0] ETC_AM_DEC = 2'h3;
    localparam logic [1:0] ETC_SZ_WORD = 2'h1;
    localparam logic [1:0] ETC_SZ_LONG = 2'h2;
    localparam logic [1:0] ETC_DESC_RD_LAST = 2'h3;
    localparam logic [1:0] ETC_DESC_WB_LAST = 2'h2;
    localparam logic [1:0] ETC_FIN_WAIT = 2'h3;
    localparam logic [16:0] ETC_BLK_FULL = 17'h10000;
    typedef enum logic [3:0] {
        S_IDLE, S_VEC, S_DRD, S_DATR, S_DATW, S_INT, S_DWB, S_FIN, S_WAIT
    } etc_state_e;
endpackage

// >>> etc_ctl_if.sv
// control and status between register slave and transfer core
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface etc_ctl_if;
    import etc_pkg::*;
    logic [15:0] base;
    logic [ETC_NSRC-1:0] en;
    logic sw_flag;
    logic [7:0] sw_vec;
    logic [ETC_NSRC-1:0] en_clr;
    logic sw_clr;
    logic busy;
    logic act_hw;
    logic [ETC_SIW-1:0] act_src;
    modport regs (output base, en, sw_flag, sw_vec,
                  input en_clr, sw_clr, busy, act_hw, act_src);
    modport core (input base, en, sw_flag, sw_vec,
                  output en_clr, sw_clr, busy, act_hw, act_src);
endinterface

// >>> etc_regs.sv
// AXI4-Lite register slave of the event transfer controller
// assumes one write and one read outstanding at most
`timescale 1ns/1ps
module etc_regs (
    input wire logic i_clk, // system clock
    input wire logic i_sys_rst, // sync reset, high
    input wire logic i_awvalid, // write address valid
    input wire logic [etc_pkg::ETC_AW-1:0] i_awaddr, // write address
    output logic o_awready, // write address ready
    input wire logic i_wvalid, // write data valid
    input wire logic [31:0] i_wdata, // write data
    input wire logic [3:0] i_wstrb, // byte strobes
    output logic o_wready, // write data ready
    output logic o_bvalid, // write response valid
    output logic [1:0] o_bresp, // write response
    input wire logic i_bready, // write response ready
    input wire logic i_arvalid, // read address valid
    input wire logic [etc_pkg::ETC_AW-1:0] i_araddr, // read address
    output logic o_arready, // read address ready
    output logic o_rvalid, // read data valid
    output logic [31:0] o_rdata, // read data
    output logic [1:0] o_rresp, // read response
    input wire logic i_rready, // read data ready
    etc_ctl_if.regs ctl // control to core
);
    import etc_pkg::*;
    logic aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
    logic [ETC_AW-1:0] awaddr_r;
    logic [31:0] wdata_r, rdata_r;
    logic [3:0] wstrb_r;
    logic [1:0] bresp_r, rresp_r;
    logic [15:0] base_r;
    logic [ETC_NSRC-1:0] en_r;
    logic flag_r;
    logic [7:0] vec_r;
    wire do_wr = aw_hold_r && w_hold_r;
    wire wr_base = do_wr && awaddr_r == ETC_REG_BASE;
    wire wr_en = do_wr && awaddr_r == ETC_REG_EN;
    wire wr_swc = do_wr && awaddr_r == ETC_REG_SWC;
    wire wr_hit = wr_base || wr_en || wr_swc || awaddr_r == ETC_REG_STAT;
    wire rd_go = i_arvalid && o_arready;
    wire rd_hit = i_araddr == ETC_REG_BASE || i_araddr == ETC_REG_EN ||
                  i_araddr == ETC_REG_SWC || i_araddr == ETC_REG_STAT;
    wire [31:0] stat_w = {19'h0, ctl.act_hw, 1'h0, ctl.act_src, 7'h0, ctl.busy};
    wire [31:0] rd_mux = (i_araddr == ETC_REG_BASE) ? {16'h0, base_r} :
                         (i_araddr == ETC_REG_EN) ? {24'h0, en_r} :
                         (i_araddr == ETC_REG_SWC) ? {23'h0, flag_r, vec_r} :
                         (i_araddr == ETC_REG_STAT) ? stat_w : 32'h0;
    assign o_awready = !aw_hold_r && !bvalid_r;
    assign o_wready = !w_hold_r && !bvalid_r;
    assign o_arready = !rvalid_r;
    assign o_bvalid = bvalid_r;
    assign o_bresp = bresp_r;
    assign o_rvalid = rvalid_r;
    assign o_rdata = rdata_r;
    assign o_rresp = rresp_r;
    assign ctl.base = base_r;
    assign ctl.en = en_r;
    assign ctl.sw_flag = flag_r;
    assign ctl.sw_vec = vec_r;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst || do_wr) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
        end else begin
            aw_hold_r <= aw_hold_r || (i_awvalid && o_awready);
            w_hold_r <= w_hold_r || (i_wvalid && o_wready);
        end
        if (i_awvalid && o_awready) awaddr_r <= i_awaddr;
        if (i_wvalid && o_wready) begin
            wdata_r <= i_wdata;
            wstrb_r <= i_wstrb;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            bvalid_r <= 1'b0;
            bresp_r <= ETC_RESP_OK;
            rvalid_r <= 1'b0;
            rresp_r <= ETC_RESP_OK;
            rdata_r <= 32'h0;
        end else begin
            if (do_wr) begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_hit ? ETC_RESP_OK : ETC_RESP_ERR;
            end else if (i_bready) bvalid_r <= 1'b0;
            if (rd_go) begin
                rvalid_r <= 1'b1;
                rdata_r <= rd_mux;
                rresp_r <= rd_hit ? ETC_RESP_OK : ETC_RESP_ERR;
            end else if (i_rready) rvalid_r <= 1'b0;
        end
    end

    // a software write beats a same-cycle hardware clear
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            base_r <= 16'h0;
            en_r <= '0;
            flag_r <= 1'b0;
            vec_r <= 8'h00;
        end else begin
            if (wr_base && wstrb_r[0]) base_r[7:0] <= wdata_r[7:0];
            if (wr_base && wstrb_r[1]) base_r[15:8] <= wdata_r[15:8];
            if (wr_en && wstrb_r[0]) en_r <= wdata_r[ETC_NSRC-1:0];
            else en_r <= en_r & ~ctl.en_clr;
            if (wr_swc && wstrb_r[0]) vec_r <= wdata_r[7:0];
            if (wr_swc && wstrb_r[1]) flag_r <= wdata_r[ETC_SWC_FLAG];
            else if (ctl.sw_clr) flag_r <= 1'b0;
        end
    end
endmodule

// >>> etc_core.sv
// event transfer controller: repeat, block and normal mode transfers
// assumes a single-beat bus master port answered by i_bus_ack
// Operation
// - repeat mode moves one unit per activation
// - repeat count 1-256, running byte reloads
// - repeat side address restored from initial word
// - other address increments, decrements or stays
// - repeat without select bit never interrupts CPU
// - block mode moves whole block per activation
// - block side address written back initial
// - block count decrements, interrupt at one
// - descriptor four reads, three write-backs
// - vector, descriptor, internal, data accesses
// - memory access costs set by bus wait
// - peripheral access costs set by bus wait
// - chain bit runs the next descriptor
// - enabled pending source starts a transfer
// - clear source or clear enable at end
// - software flag cleared unless CPU interrupt
// - descriptor address is base plus vector
// - descriptor words read in fixed order
// - software vector fetched from base plus number
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module etc_core (
    input wire logic i_clk, // system clock
    input wire logic i_sys_rst, // sync reset, high
    input wire logic i_awvalid, // write address valid
    input wire logic [etc_pkg::ETC_AW-1:0] i_awaddr, // write address
    output logic o_awready, // write address ready
    input wire logic i_wvalid, // write data valid
    input wire logic [31:0] i_wdata, // write data
    input wire logic [3:0] i_wstrb, // byte strobes
    output logic o_wready, // write data ready
    output logic o_bvalid, // write response valid
    output logic [1:0] o_bresp, // write response
    input wire logic i_bready, // write response ready
    input wire logic i_arvalid, // read address valid
    input wire logic [etc_pkg::ETC_AW-1:0] i_araddr, // read address
    output logic o_arready, // read address ready
    output logic o_rvalid, // read data valid
    output logic [31:0] o_rdata, // read data
    output logic [1:0] o_rresp, // read response
    input wire logic i_rready, // read data ready
    input wire logic [etc_pkg::ETC_NSRC-1:0] i_src_req, // source levels
    output logic [etc_pkg::ETC_NSRC-1:0] o_src_clr, // clear source pulse
    output logic o_cpu_req, // cpu interrupt pulse
    output logic o_bus_req, // bus access request
    output logic o_bus_we, // bus write
    output logic [1:0] o_bus_size, // 0 byte 1 word 2 long
    output logic [31:0] o_bus_addr, // bus byte address
    output logic [31:0] o_bus_wdata, // bus write data
    input wire logic [31:0] i_bus_rdata, // bus read data
    input wire logic i_bus_ack // access done
);
    import etc_pkg::*;
    etc_ctl_if ctl ();
    etc_regs u_regs (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_awvalid(i_awvalid), .i_awaddr(i_awaddr), .o_awready(o_awready),
        .i_wvalid(i_wvalid), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
        .o_wready(o_wready), .o_bvalid(o_bvalid), .o_bresp(o_bresp),
        .i_bready(i_bready), .i_arvalid(i_arvalid), .i_araddr(i_araddr),
        .o_arready(o_arready), .o_rvalid(o_rvalid), .o_rdata(o_rdata),
        .o_rresp(o_rresp), .i_rready(i_rready), .ctl(ctl.regs)
    );

    etc_state_e state_r;
    logic [ETC_NSRC-1:0] sync1_r, sync2_r, src_clr_r, en_clr_r;
    logic sw_clr_r, cpu_req_r, act_hw_r, irq_r, sw_hold_r;
    logic [ETC_SIW-1:0] act_src_r, sel_idx;
    logic [1:0] idx_r;
    logic [31:0] vec_addr_r, desc_r, init_r, src_r, dst_r, src0_r, dst0_r;
    logic [31:0] data_r;
    logic [15:0] mode_r, cnt_r;
    logic [16:0] blk_left_r;

    // two-stage synchroniser on the source pins
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= i_src_req;
            sync2_r <= sync1_r;
        end
    end

    wire [ETC_NSRC-1:0] pend = sync2_r & ctl.en;
    wire hw_go = |pend;
    wire sw_go = ctl.sw_flag && !sw_hold_r;
    always_comb begin
        sel_idx = '0;
        for (int i = ETC_NSRC - 1; i >= 0; i--) begin
            if (pend[i]) sel_idx = ETC_SIW'(i);
        end
    end

    wire [1:0] md = mode_r[ETC_MW_MD+:2];
    wire [1:0] sm = mode_r[ETC_MW_SM+:2];
    wire [1:0] dm = mode_r[ETC_MW_DM+:2];
    wire [1:0] sz = mode_r[ETC_MW_SZ+:2];
    wire side = mode_r[ETC_MW_SIDE];
    wire isel = mode_r[ETC_MW_ISEL];
    wire chain = mode_r[ETC_MW_CHAIN];
    wire is_rep = md == ETC_MD_REPEAT;
    wire is_blk = md == ETC_MD_BLOCK;
    wire [7:0] run = cnt_r[7:0];
    wire [7:0] rel = cnt_r[15:8];
    wire [31:0] step = 32'h1 << sz;
    wire [31:0] src_step = (sm == ETC_AM_INC) ? src_r + step :
                           (sm == ETC_AM_DEC) ? src_r - step : src_r;
    wire [31:0] dst_step = (dm == ETC_AM_INC) ? dst_r + step :
                           (dm == ETC_AM_DEC) ? dst_r - step : dst_r;
    wire rep_wrap = is_rep && run == 8'h01;
    // running byte reloads from the held copy, which stays untouched
    wire [15:0] cnt_wb = !is_rep ? cnt_r - 16'h1 :
                         rep_wrap ? {rel, rel} : {rel, run - 8'h01};
    wire [31:0] src_wb = (rep_wrap && side) ? init_r :
                         (is_blk && side) ? src0_r : src_r;
    wire [31:0] dst_wb = (rep_wrap && !side) ? init_r :
                         (is_blk && !side) ? dst0_r : dst_r;
    // repeat mode interrupts only on the select bit
    wire irq_wb = isel || (!is_rep && cnt_r == 16'h1);
    wire [15:0] blen = init_r[15:0];
    wire [16:0] blk_len = !is_blk ? 17'h1 :
                          (blen == 16'h0) ? ETC_BLK_FULL : {1'b0, blen};
    wire [31:0] wb_off = (idx_r == 2'h0) ? 32'h0 : 32'h4 + {28'h0, idx_r, 2'h0};
    wire bus_ok = o_bus_req && i_bus_ack;

    // bus presentation; every access waits on i_bus_ack, so cost is the bus's
    always_comb begin
        o_bus_req = 1'b1;
        o_bus_we = 1'b0;
        o_bus_size = ETC_SZ_LONG;
        o_bus_addr = 32'h0;
        o_bus_wdata = 32'h0;
        case (state_r)
            S_VEC: begin
                o_bus_size = ETC_SZ_WORD;
                o_bus_addr = vec_addr_r;
            end
            S_DRD: o_bus_addr = desc_r + {28'h0, idx_r, 2'h0};
            S_DATR: begin
                o_bus_size = sz;
                o_bus_addr = src_r;
            end
            S_DATW: begin
                o_bus_we = 1'b1;
                o_bus_size = sz;
                o_bus_addr = dst_r;
                o_bus_wdata = data_r;
            end
            S_DWB: begin
                o_bus_we = 1'b1;
                o_bus_addr = desc_r + wb_off;
                o_bus_wdata = (idx_r == 2'h0) ? {mode_r, cnt_r} :
                              (idx_r == 2'h1) ? src_r : dst_r;
            end
            default: o_bus_req = 1'b0;
        endcase
    end

    // one activation runs from vector fetch to write-back before the next
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_r <= S_IDLE;
            idx_r <= 2'h0;
        end else begin
            case (state_r)
                S_IDLE: if (hw_go || sw_go) state_r <= S_VEC;
                S_VEC: if (bus_ok) begin
                    state_r <= S_DRD;
                    idx_r <= 2'h0;
                end
                S_DRD: if (bus_ok) begin
                    idx_r <= idx_r + 2'h1;
                    if (idx_r == ETC_DESC_RD_LAST) state_r <= S_DATR;
                end
                S_DATR: if (bus_ok) state_r <= S_DATW;
                S_DATW: if (bus_ok) begin
                    state_r <= (blk_left_r == 17'h1) ? S_INT : S_DATR;
                end
                S_INT: begin
                    state_r <= S_DWB;
                    idx_r <= 2'h0;
                end
                S_DWB: if (bus_ok) begin
                    idx_r <= idx_r + 2'h1;
                    if (idx_r == ETC_DESC_WB_LAST) begin
                        idx_r <= 2'h0;
                        state_r <= chain ? S_DRD : S_FIN;
                    end
                end
                S_FIN: state_r <= S_WAIT;
                S_WAIT: begin
                    idx_r <= idx_r + 2'h1;
                    if (idx_r == ETC_FIN_WAIT) state_r <= S_IDLE;
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    // activation capture and descriptor words
    always_ff @(posedge i_clk) begin
        if (state_r == S_IDLE) begin
            act_hw_r <= hw_go;
            act_src_r <= sel_idx;
            vec_addr_r <= hw_go ? ETC_HW_VEC_BASE + {28'h0, sel_idx, 1'b0} :
                          ETC_SW_VEC_BASE + {24'h0, ctl.sw_vec};
        end
        if (state_r == S_VEC && bus_ok) desc_r <= {ctl.base, i_bus_rdata[15:0]};
        if (state_r == S_DWB && bus_ok && idx_r == ETC_DESC_WB_LAST) begin
            desc_r <= desc_r + ETC_DESC_STRIDE;
        end
        if (state_r == S_DRD && bus_ok) begin
            case (idx_r)
                2'h0: {mode_r, cnt_r} <= i_bus_rdata;
                2'h1: init_r <= i_bus_rdata;
                2'h2: begin
                    src_r <= i_bus_rdata;
                    src0_r <= i_bus_rdata;
                end
                default: begin
                    dst_r <= i_bus_rdata;
                    dst0_r <= i_bus_rdata;
                    blk_left_r <= blk_len;
                end
            endcase
        end
        if (state_r == S_DATR && bus_ok) data_r <= i_bus_rdata;
        if (state_r == S_DATW && bus_ok) begin
            src_r <= src_step;
            dst_r <= dst_step;
            blk_left_r <= blk_left_r - 17'h1;
        end
        if (state_r == S_INT) begin
            cnt_r <= cnt_wb;
            src_r <= src_wb;
            dst_r <= dst_wb;
            irq_r <= irq_wb;
        end
    end

    // completion hand-off to source, enable, flag and cpu
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || state_r != S_FIN) begin
            src_clr_r <= '0;
            en_clr_r <= '0;
            sw_clr_r <= 1'b0;
            cpu_req_r <= 1'b0;
        end else begin
            src_clr_r <= (act_hw_r && !irq_r) ? ETC_NSRC'(1) << act_src_r : '0;
            en_clr_r <= (act_hw_r && irq_r) ? ETC_NSRC'(1) << act_src_r : '0;
            sw_clr_r <= !act_hw_r && !irq_r;
            cpu_req_r <= irq_r;
        end
    end

    // a kept flag must not restart until software clears it
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || !ctl.sw_flag) sw_hold_r <= 1'b0;
        else if (state_r == S_FIN && !act_hw_r && irq_r) sw_hold_r <= 1'b1;
    end

    assign o_src_clr = src_clr_r;
    assign o_cpu_req = cpu_req_r;
    assign ctl.en_clr = en_clr_r;
    assign ctl.sw_clr = sw_clr_r;
    assign ctl.busy = state_r != S_IDLE;
    assign ctl.act_hw = act_hw_r;
    assign ctl.act_src = act_src_r;

    logic [2:0] rd_cnt_r;
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || (state_r == S_DWB && bus_ok && idx_r == ETC_DESC_WB_LAST)) begin
            rd_cnt_r <= 3'h0;
        end else if (state_r == S_DRD && bus_ok) rd_cnt_r <= rd_cnt_r + 3'h1;
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    bus_hold_a: assert property (o_bus_req && !i_bus_ack |=> o_bus_req && $stable(o_bus_addr))
        else $error("bus request dropped before ack");
    desc_base_a: assert property (state_r == S_DRD |-> o_bus_addr[31:16] == ctl.base)
        else $error("descriptor address not under base");
    sw_vec_a: assert property (state_r == S_VEC && !act_hw_r
        |-> o_bus_addr == ETC_SW_VEC_BASE + {24'h0, ctl.sw_vec})
        else $error("software vector address wrong");
    rep_reload_a: assert property (state_r == S_INT && rep_wrap
        |=> cnt_r[7:0] == $past(cnt_r[15:8]) && cnt_r[15:8] == $past(cnt_r[15:8]))
        else $error("running count not reloaded");
    rep_noirq_a: assert property (state_r == S_INT && is_rep && !isel
        |=> !irq_r ##[2:20] state_r == S_WAIT && !o_cpu_req)
        else $error("repeat mode raised interrupt");
    blk_restore_a: assert property (state_r == S_INT && is_blk
        |=> (side ? src_r : dst_r) == $past(side ? src0_r : dst0_r))
        else $error("block side address not restored");
    blk_irq_a: assert property (state_r == S_INT && is_blk && cnt_r == 16'h1
        |=> irq_r && cnt_r == 16'h0)
        else $error("last block did not request interrupt");
    desc_reads_a: assert property (state_r == S_DWB && bus_ok && idx_r == ETC_DESC_WB_LAST
        |-> rd_cnt_r == 3'h4)
        else $error("descriptor read count wrong");
    done_clr_a: assert property (o_cpu_req |-> o_src_clr == '0 && !sw_clr_r)
        else $error("source cleared with cpu interrupt");
    one_act_a: assert property (state_r == S_VEC && $past(state_r) != S_VEC
        |-> !$past(ctl.busy))
        else $error("activation overlapped");
    // completion and address checks
    hw_end_a: assert property (state_r == S_FIN && act_hw_r
        |=> (|o_src_clr) == !irq_r && (|ctl.en_clr) == irq_r && o_cpu_req == irq_r)
        else $error("hardware completion hand-off wrong");
    sw_end_a: assert property (state_r == S_FIN && !act_hw_r
        |=> ctl.sw_clr == !irq_r && o_cpu_req == irq_r && o_src_clr == '0)
        else $error("software completion hand-off wrong");
    rep_side_a: assert property (state_r == S_INT && rep_wrap
        |=> (side ? src_r : dst_r) == init_r)
        else $error("repeat side address not restored");
    blk_done_a: assert property (state_r == S_INT |-> blk_left_r == 17'h0)
        else $error("block cut short");
    dst_step_a: assert property (state_r == S_DATW && bus_ok && dm == ETC_AM_INC
        |=> dst_r == $past(dst_r) + (32'h1 << sz))
        else $error("destination address did not step");
    idle_hold_a: assert property (state_r == S_IDLE && !hw_go && !sw_go
        |=> state_r == S_IDLE)
        else $error("transfer started without enabled source");
    desc_wb_a: assert property (state_r == S_DWB && idx_r == 2'h0
        |-> o_bus_we && o_bus_addr == desc_r && o_bus_wdata == {mode_r, cnt_r})
        else $error("mode and count not written back first");

    cv_repeat: cover property (state_r == S_INT && rep_wrap);
    cv_block: cover property (state_r == S_DATW && bus_ok && blk_left_r > 17'h1);
    cv_chain: cover property (state_r == S_DWB && bus_ok && chain && idx_r == 2'h2);
    cv_sw: cover property (o_cpu_req && !act_hw_r);
    cv_blk_src: cover property (state_r == S_INT && is_blk && side);
endmodule

// >>> etc_mem_model.sv
// bus memory model that answers the controller's master port
// assumes big-endian lanes for reads, long writes only
`timescale 1ns/1ps
module etc_mem_model (
    input wire logic i_clk, // system clock
    input wire logic i_req, // access request
    input wire logic i_we, // write
    input wire logic [1:0] i_size, // access size
    input wire logic [31:0] i_addr, // byte address
    input wire logic [31:0] i_wdata, // write data
    output logic [31:0] o_rdata, // read data
    output logic o_ack // access done
);
    logic [31:0] mem [int];
    logic [31:0] w;
    int lat = 0;
    initial begin
        o_ack = 1'b0;
        o_rdata = 32'h0;
    end
    always @(posedge i_clk) begin
        w = mem.exists(i_addr[31:2]) ? mem[i_addr[31:2]] : 32'h0;
        o_ack <= 1'b0;
        o_rdata <= ~o_rdata; // released data keeps moving
        if (i_req && o_ack && i_we) begin
            mem[i_addr[31:2]] = i_wdata;
        end else if (i_req && !o_ack) begin
            if (lat == 0) begin
                o_ack <= 1'b1;
                o_rdata <= i_size == 2'h2 ? w : i_size == 2'h1 ? (i_addr[1] ? w[15:0] : w[31:16])
                    : (w >> (8 * (3 - i_addr[1:0]))) & 32'hFF;
                lat = $urandom_range(1, 0);
            end else begin
                lat = lat - 1;
            end
        end
    end
endmodule

// >>> event_transfer_repeat_block_modes_bench.sv
// self-checking bench: repeat and block activations, register port
// assumes the memory model stands on the bus master port
`timescale 1ns/1ps
module event_transfer_repeat_block_modes_bench;
    import etc_pkg::*;
    logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic awr, wr, bv, arr, rv, cpu, breq, bwe, back, c;
    logic [7:0] awa = 8'h0, ara = 8'h0, sreq = 8'h0, sclr, s;
    logic [31:0] wd = 32'h0, rd, ba, bwd, brd, q;
    logic [1:0] bres, rres, bsz, r;
    int miscompares = 0, checked = 0, k;
    initial forever #2.5 clk = ~clk;
    etc_core u_etc_core (.i_clk(clk), .i_sys_rst(rst), .i_awvalid(awv), .i_awaddr(awa),
        .o_awready(awr), .i_wvalid(wv), .i_wdata(wd), .i_wstrb(4'hF), .o_wready(wr),
        .o_bvalid(bv), .o_bresp(bres), .i_bready(bry), .i_arvalid(arv), .i_araddr(ara),
        .o_arready(arr), .o_rvalid(rv), .o_rdata(rd), .o_rresp(rres), .i_rready(rry),
        .i_src_req(sreq), .o_src_clr(sclr), .o_cpu_req(cpu), .o_bus_req(breq), .o_bus_we(bwe),
        .o_bus_size(bsz), .o_bus_addr(ba), .o_bus_wdata(bwd), .i_bus_rdata(brd), .i_bus_ack(back));
    etc_mem_model u_etc_mem_model (.i_clk(clk), .i_req(breq), .i_we(bwe), .i_size(bsz),
        .i_addr(ba), .i_wdata(bwd), .o_rdata(brd), .o_ack(back));
    function automatic logic [31:0] m(input int a);
        return u_etc_mem_model.mem[a >> 2];
    endfunction
    task automatic sm(input int a, input logic [31:0] d);
        u_etc_mem_model.mem[a >> 2] = d;
    endtask
    task print_verdict;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic axi(input logic we, input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, done;
        done = 1'b0;
        @(posedge clk);
        if (we) begin
            awv <= 1'b1; awa <= a; wv <= 1'b1; wd <= d; bry <= 1'b1;
        end else begin
            arv <= 1'b1; ara <= a; rry <= 1'b1;
        end
        for (int n = 0; n < 40 && !done; n++) begin
            @(negedge clk);
            ta = awv && awr || arv && arr;
            tw = wv && wr;
            done = we ? bv : rv;
            q = rd;
            r = we ? bres : rres;
            @(posedge clk);
            if (ta) begin awv <= 1'b0; arv <= 1'b0; end
            if (tw) wv <= 1'b0;
            if (done) begin bry <= 1'b0; rry <= 1'b0; end
        end
        if (!done) begin miscompares++; print_verdict(); end
    endtask
    task automatic wait_done;
        c = 1'b0; s = 8'h0;
        for (int n = 0; n < 300 && !(c || s != 8'h0); n++) begin
            @(negedge clk);
            c = cpu;
            s = sclr;
        end
        if (!(c || s != 8'h0)) begin miscompares++; print_verdict(); end
        @(posedge clk);
        sreq <= 8'h0;
        repeat (8) @(posedge clk);
    endtask
    initial begin
        k = $urandom(32'hB1C1);
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        axi(1'b1, ETC_REG_BASE, 32'h1); chk(r, ETC_RESP_OK);
        axi(1'b1, ETC_REG_EN, 32'h4);
        sm(32'h404, 32'h0100_0100);
        sm(32'h420, 32'h0200_0200);
        sm(32'h10100, 32'hA420_0202); sm(32'h10104, 32'h3000);
        sm(32'h10108, 32'h2000); sm(32'h1010C, 32'h3008);
        sm(32'h2000, $urandom); sm(32'h2004, $urandom);
        for (k = 0; k < 2; k++) begin
            @(posedge clk);
            sreq <= 8'h04;
            wait_done();
            chk(s, 8'h04);
            chk(c, 1'b0);
            chk(m(32'h10100), {16'hA420, 8'h02, k == 0 ? 8'h01 : 8'h02});
            chk(m(32'h10104), 32'h3000);
            chk(m(32'h10108), 32'h2004 + 4 * k);
            chk(m(32'h1010C), k == 0 ? 32'h300C : 32'h3000);
            chk(m(32'h3008 + 4 * k), m(32'h2000 + 4 * k));
        end
        axi(1'b0, ETC_REG_EN, 32'h0); chk(q, 32'h4);
        $display("repeat test done");
        sm(32'h10200, 32'hAA20_0001); sm(32'h10204, 32'h2);
        sm(32'h10208, 32'h2000); sm(32'h1020C, 32'h4000);
        axi(1'b0, ETC_REG_SWC, 32'h0); chk(q[8], 1'b0);
        axi(1'b1, ETC_REG_SWC, 32'h120);
        wait_done();
        chk(c, 1'b1);
        chk(s, 8'h0);
        chk(m(32'h10200), 32'hAA20_0000);
        chk(m(32'h10204), 32'h2);
        chk(m(32'h10208), 32'h2000);
        chk(m(32'h1020C), 32'h4008);
        chk(m(32'h4000), m(32'h2000));
        chk(m(32'h4004), m(32'h2004));
        axi(1'b0, ETC_REG_SWC, 32'h0); chk(q[8], 1'b1);
        axi(1'b1, ETC_REG_SWC, 32'h0);
        $display("block test done");
        axi(1'b0, 8'h40, 32'h0); chk(r, ETC_RESP_ERR);
        axi(1'b0, ETC_REG_STAT, 32'h0); chk(q[0], 1'b0);
        $display("register test done");
        print_verdict();
    end
endmodule
